// ===== core/exc_pkg.sv
// exception unit package: constants, states and encodings
// assumes a byte-wide memory port and a 20-bit address space
package exc_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int MASK_W = 8;
  localparam int LEVEL_W = 3;
  localparam int SPECIAL_N = 6;
  localparam int SOFT_N = 4;
  localparam logic [ADDR_W-1:0] TABLE_STRIDE_SHIFT = 20'h00001;
  localparam logic [ADDR_W-1:0] CORR_OFFSET = 20'h00001;
  localparam logic [ADDR_W-1:0] PUSH_STEP = 20'h00001;
  localparam logic [ADDR_W-1:0] RESET_SP = 20'h00000;
  localparam logic [2:0] ENTRY_BYTES = 3'h5;
  localparam logic [3:0] SPECIAL_RESET_BIT = 4'h0;
  localparam logic [7:0] SPECIAL_VECTOR_BASE = 8'hf8;
  localparam logic [7:0] SOFT_VECTOR_BASE = 8'hf0;
  typedef enum logic [1:0] {
    INST_ORDINARY,
    INST_STRING,
    INST_SUM_PRODUCTS
  } inst_kind_t;
  typedef enum {
    ST_IDLE,
    ST_WAIT_INST,
    ST_ENTRY_PUSH,
    ST_ENTRY_LOAD,
    ST_CTX_NUMBER,
    ST_CTX_MASK,
    ST_CTX_POP,
    ST_CTX_CORR,
    ST_CTX_ADJUST
  } exc_state_t;
endpackage

// ===== core/priority_pick.sv
// request arbiter: picks the highest priority request of the cycle
// assumes requests are already synchronous to the core clock
`timescale 1ns/1ps
module priority_pick #(
  parameter int N = 8
) (
  // requests
  input wire logic [N-1:0] req,
  // result
  output logic any,
  output logic [$clog2(N)-1:0] index
);
  always_comb begin
    any = 1'b0;
    index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        index = i[$clog2(N)-1:0];
      end
    end
  end
endmodule

// ===== core/interrupt_and_context_restore.sv
// interrupt entry sequencer and task context restore engine
// assumes a one-cycle byte memory port and synchronous core handshakes
// Summary of operation
// RQ1: mask byte address is task number times two plus table base.
// RQ2: pop masked registers from stack; stack pointer stays unchanged meanwhile.
// RQ3: read correction byte at mask address plus one.
// RQ4: finally add correction byte to stack pointer.
// RQ5: six special sources nonmaskable; peripheral sources maskable.
// RQ6: maskable needs enable flag and level above processor level.
// RQ7: software interrupt, break, overflow, undefined raise on execution.
// RQ8: ordinary instruction completes, then priorities resolve, entry next cycle; code fixes the vector when the request is first seen in ST_IDLE.
// RQ9: string and sum-of-products instructions suspend mid-way for entry.
// RQ10: entry pushes old flags and program counter, loads interrupt registers.
// RQ11: after entry the service routine starts.
// RQ12: during entry only reset is accepted.
// RQ13: each mask bit selects one register for transfer.
// RQ14: first operand is a 16-bit address holding the task number.
// RQ15: mask bit order reverses the context save order.
// RQ16: suspended instructions resume from saved intermediate state.
`timescale 1ns/1ps
module interrupt_and_context_restore #(
  parameter int PERIPH_N = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // interrupt sources
  input wire logic [exc_pkg::SPECIAL_N-1:0] SPECIAL_REQ,
  input wire logic [PERIPH_N-1:0] PERIPH_REQ,
  input wire logic [PERIPH_N*exc_pkg::LEVEL_W-1:0] PERIPH_LEVEL,
  input wire logic [exc_pkg::SOFT_N-1:0] SOFT_EXEC,
  // processor state
  input wire logic ENABLE_FLAG,
  input wire logic [exc_pkg::LEVEL_W-1:0] PROCESSOR_PRIORITY_LEVEL,
  input wire logic [15:0] FLAG_REGISTER,
  input wire logic [exc_pkg::ADDR_W-1:0] PC,
  input wire logic [exc_pkg::ADDR_W-1:0] SP_IN,
  input wire exc_pkg::inst_kind_t INST_KIND,
  input wire logic INST_DONE,
  // context restore command
  input wire logic RESTORE_START,
  input wire logic [15:0] TASK_NUMBER_POINTER,
  input wire logic [exc_pkg::ADDR_W-1:0] CONTEXT_TABLE_BASE,
  // memory port
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [exc_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [exc_pkg::DATA_W-1:0] MEM_WDATA,
  input wire logic [exc_pkg::DATA_W-1:0] MEM_RDATA,
  // results to the core
  output logic SUSPEND,
  output logic ENTRY_BUSY,
  output logic SERVICE_START,
  output logic [7:0] VECTOR,
  output logic [exc_pkg::ADDR_W-1:0] SP_OUT,
  output logic REG_LOAD,
  output logic [2:0] REG_INDEX,
  output logic RESTORE_DONE
);
  import exc_pkg::*;

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  logic [SPECIAL_N+PERIPH_N-1:0] pin_s1, pin_s2;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {PERIPH_REQ, SPECIAL_REQ};
      pin_s2 <= pin_s1;
    end
  end

  // ---------------------------------------------------------------
  // request qualification
  // ---------------------------------------------------------------
  logic [SPECIAL_N-1:0] special_q;
  logic [PERIPH_N-1:0] periph_q;
  assign special_q = pin_s2[SPECIAL_N-1:0]; // RQ5
  genvar g;
  generate
    for (g = 0; g < PERIPH_N; g++) begin : gen_mask
      assign periph_q[g] = pin_s2[SPECIAL_N+g] && ENABLE_FLAG
        && (PERIPH_LEVEL[g*LEVEL_W +: LEVEL_W] > PROCESSOR_PRIORITY_LEVEL); // RQ6
    end
  endgenerate

  logic sp_any, sw_any, pe_any;
  logic [$clog2(SPECIAL_N)-1:0] sp_idx;
  logic [$clog2(SOFT_N)-1:0] sw_idx;
  logic [$clog2(PERIPH_N)-1:0] pe_idx;
  priority_pick #(.N(SPECIAL_N)) u_sp (.req(special_q), .any(sp_any), .index(sp_idx));
  priority_pick #(.N(SOFT_N)) u_sw (.req(SOFT_EXEC), .any(sw_any), .index(sw_idx)); // RQ7
  priority_pick #(.N(PERIPH_N)) u_pe (.req(periph_q), .any(pe_any), .index(pe_idx));

  logic reset_req;
  assign reset_req = special_q[SPECIAL_RESET_BIT[$clog2(SPECIAL_N)-1:0]];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    exc_state_t st;
    logic [2:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] sp;
    logic [MASK_W-1:0] mask;
    logic [7:0] vec;
    logic [39:0] save;
    logic suspended;
  } state_t;
  state_t s_reg, s_next;

  logic irq_any;
  logic [7:0] irq_vec;
  always_comb begin
    irq_any = sp_any || sw_any || pe_any;
    if (sp_any) begin
      irq_vec = SPECIAL_VECTOR_BASE + 8'(sp_idx);
    end else if (sw_any) begin
      irq_vec = SOFT_VECTOR_BASE + 8'(sw_idx);
    end else begin
      irq_vec = 8'(pe_idx);
    end
  end

  always_comb begin
    s_next = s_reg;
    unique case (s_reg.st)
      ST_IDLE: begin
        if (irq_any) begin
          if (INST_KIND != INST_ORDINARY) begin
            s_next.suspended = 1'b1; // RQ9 RQ16
            s_next.st = ST_ENTRY_PUSH;
          end else begin
            s_next.st = INST_DONE ? ST_ENTRY_PUSH : ST_WAIT_INST; // RQ8
          end
          s_next.vec = irq_vec;
          s_next.sp = SP_IN;
          s_next.save = {FLAG_REGISTER, 4'h0, PC}; // RQ10
          s_next.cnt = '0;
        end else if (RESTORE_START) begin
          s_next.addr = {4'h0, TASK_NUMBER_POINTER}; // RQ14
          s_next.sp = SP_IN;
          s_next.st = ST_CTX_NUMBER;
        end
      end
      ST_WAIT_INST: begin
        if (INST_DONE) begin
          s_next.st = ST_ENTRY_PUSH; // RQ8
          s_next.save = {FLAG_REGISTER, 4'h0, PC};
        end
      end
      ST_ENTRY_PUSH: begin
        s_next.sp = s_reg.sp - PUSH_STEP; // RQ10
        s_next.save = {s_reg.save[31:0], 8'h00};
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_next.cnt == ENTRY_BYTES) begin
          s_next.st = ST_ENTRY_LOAD;
        end
      end
      ST_ENTRY_LOAD: begin
        s_next.st = ST_IDLE; // RQ11
        s_next.suspended = 1'b0;
      end
      ST_CTX_NUMBER: begin
        s_next.addr = (ADDR_W'(MEM_RDATA) << TABLE_STRIDE_SHIFT) + CONTEXT_TABLE_BASE; // RQ1
        s_next.st = ST_CTX_MASK;
      end
      ST_CTX_MASK: begin
        s_next.mask = MEM_RDATA; // RQ1
        s_next.cnt = '0;
        s_next.st = ST_CTX_POP;
      end
      ST_CTX_POP: begin
        s_next.cnt = s_reg.cnt + 3'h1; // RQ13
        if (s_reg.cnt == 3'h7) begin
          s_next.st = ST_CTX_CORR;
        end
      end
      ST_CTX_CORR: begin
        s_next.st = ST_CTX_ADJUST;
      end
      ST_CTX_ADJUST: begin
        s_next.sp = s_reg.sp + ADDR_W'(MEM_RDATA); // RQ4
        s_next.st = ST_IDLE;
      end
      default: s_next.st = ST_IDLE;
    endcase
    if (reset_req && s_reg.st != ST_IDLE) begin
      s_next.st = ST_IDLE; // RQ12
      s_next.sp = RESET_SP;
      s_next.suspended = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: ST_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic pop_sel;
  logic [2:0] pop_reg;
  assign pop_reg = 3'h7 - s_reg.cnt; // RQ15
  assign pop_sel = s_reg.mask[s_reg.cnt];
  // pop address counts bytes selected so far; sp itself is untouched
  logic [ADDR_W-1:0] pop_off;
  always_comb begin
    pop_off = '0;
    for (int i = 0; i < MASK_W; i++) begin
      if (i < s_reg.cnt && s_reg.mask[i]) begin
        pop_off = pop_off + PUSH_STEP;
      end
    end
  end

  always_comb begin
    MEM_RD = 1'b0;
    MEM_WR = 1'b0;
    MEM_ADDR = s_reg.addr;
    MEM_WDATA = s_reg.save[39:32];
    unique case (s_reg.st)
      ST_ENTRY_PUSH: begin
        MEM_WR = 1'b1;
        MEM_ADDR = s_reg.sp - PUSH_STEP;
      end
      ST_CTX_NUMBER, ST_CTX_MASK: MEM_RD = 1'b1;
      ST_CTX_POP: begin
        MEM_RD = pop_sel; // RQ2
        MEM_ADDR = s_reg.sp + pop_off;
      end
      ST_CTX_CORR, ST_CTX_ADJUST: begin
        MEM_RD = 1'b1;
        MEM_ADDR = s_reg.addr + CORR_OFFSET; // RQ3
      end
      default: ;
    endcase
  end

  assign SUSPEND = s_reg.suspended;
  assign ENTRY_BUSY = s_reg.st == ST_ENTRY_PUSH || s_reg.st == ST_ENTRY_LOAD;
  assign SERVICE_START = s_reg.st == ST_ENTRY_LOAD;
  assign VECTOR = s_reg.vec;
  assign SP_OUT = s_reg.sp;
  assign REG_LOAD = s_reg.st == ST_CTX_POP && pop_sel;
  assign REG_INDEX = pop_reg;
  assign RESTORE_DONE = s_reg.st == ST_CTX_ADJUST;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!rst_n);
  AST_POP_SP: assert property (s_reg.st == ST_CTX_POP && !reset_req |=> $stable(s_reg.sp)) // RQ2
    else $error("sp moved during pop");
  AST_ADJ: assert property (s_reg.st == ST_CTX_ADJUST && !reset_req
    |=> s_reg.sp == $past(s_reg.sp) + ADDR_W'($past(MEM_RDATA))) // RQ4
    else $error("sp not corrected");
  AST_CORR_ADDR: assert property (s_reg.st == ST_CTX_CORR |-> MEM_ADDR == s_reg.addr + 20'h1) // RQ3
    else $error("bad correction address");
  AST_TABLE: assert property (s_reg.st == ST_CTX_NUMBER && !reset_req
    |=> s_reg.addr == ADDR_W'($past(MEM_RDATA)) * 2 + $past(CONTEXT_TABLE_BASE)) // RQ1
    else $error("bad table address");
  AST_ENTRY_LEN: assert property ($rose(ENTRY_BUSY) && !reset_req
    |-> MEM_WR [*5] ##1 SERVICE_START) // RQ10
    else $error("entry length wrong");
  AST_SERVICE: assert property (SERVICE_START && !reset_req |=> s_reg.st == ST_IDLE) // RQ11
    else $error("service not started");
  AST_MASKED: assert property (s_reg.st == ST_IDLE && !ENABLE_FLAG && !sp_any && !sw_any
    && !RESTORE_START |=> s_reg.st == ST_IDLE) // RQ6
    else $error("masked request taken");
  AST_SUSP: assert property (s_reg.st == ST_IDLE && irq_any && INST_KIND != INST_ORDINARY
    && !reset_req |=> SUSPEND && ENTRY_BUSY) // RQ9
    else $error("string not suspended");
  AST_WAIT: assert property (s_reg.st == ST_WAIT_INST && !INST_DONE && !reset_req
    |=> s_reg.st == ST_WAIT_INST) // RQ8
    else $error("entry before instruction end");
  AST_LOCK: assert property (ENTRY_BUSY && !reset_req |=> s_reg.vec == $past(s_reg.vec)) // RQ12
    else $error("request taken during entry");
  COV_ENTRY: cover property (SERVICE_START);
  COV_SUSP: cover property (SUSPEND && SERVICE_START);
  COV_RESTORE: cover property (RESTORE_DONE);
  COV_POP: cover property (REG_LOAD);
endmodule

// ===== sim/stack_mem_model.sv
// byte-wide stack and context table memory facing the exception unit
// assumes a zero-wait port: read data in the cycle of the read strobe
`timescale 1ns/1ps
module stack_mem_model (
  // core clock
  input wire logic clk,
  // memory port
  input wire logic rd,
  input wire logic wr,
  input wire logic [exc_pkg::ADDR_W-1:0] addr,
  input wire logic [exc_pkg::DATA_W-1:0] wdata,
  output logic [exc_pkg::DATA_W-1:0] rdata
);
  import exc_pkg::*;
  logic [7:0] mem [0:4095];
  logic [7:0] last = 8'h00;
  // idle bus shows the inverse of the last byte read
  always_comb rdata = rd ? mem[addr[11:0]] : ~last;
  always @(posedge clk) begin
    if (rd) last <= mem[addr[11:0]];
    if (wr) mem[addr[11:0]] <= wdata;
  end
endmodule

// ===== sim/tb_top.sv
// bench for the exception unit: table of requests, then hand-written cases
// assumes the stack memory model answers reads in the same cycle
`timescale 1ns/1ps
module tb_top;
  import exc_pkg::*;
  typedef struct {
    logic [5:0] sp; logic [3:0] so; logic [7:0] pr; logic [2:0] lv;
    logic en; logic [2:0] pl; logic take; logic [7:0] vec;
  } row_t;
  // --------------------------------------------------
  // signals
  // --------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] special_req = 6'h00;
  logic [7:0] periph_req = 8'h00;
  logic [23:0] periph_level = 24'h000000;
  logic [3:0] soft_exec = 4'h0;
  logic enable_flag = 1'b0;
  logic inst_done = 1'b1;
  logic restore_start = 1'b0;
  logic [2:0] ppl = 3'h0;
  logic [15:0] flags = 16'hc35a;
  logic [19:0] pc = 20'h9abcd;
  logic [19:0] sp_in = 20'h00800;
  logic [15:0] task_ptr = 16'h0100;
  logic [19:0] table_base = 20'h00200;
  inst_kind_t kinds [2] = '{INST_STRING, INST_SUM_PRODUCTS};
  inst_kind_t inst_kind = INST_ORDINARY;
  logic mem_rd, mem_wr, suspend, entry_busy, service_start, reg_load, restore_done;
  logic [19:0] mem_addr, sp_out;
  logic [7:0] mem_wdata, mem_rdata, vector;
  logic [2:0] reg_index;
  int error_cnt = 0;
  int n_compared = 0;
  int n, p;
  logic [2:0] exp_idx [4] = '{3'h7, 3'h5, 3'h2, 3'h0};
  row_t rows[11] = '{
    '{6'h02, 4'h0, 8'h00, 3'h0, 1'b0, 3'h7, 1'b1, 8'hf9},
    '{6'h08, 4'h0, 8'h00, 3'h0, 1'b0, 3'h7, 1'b1, 8'hfb},
    '{6'h20, 4'h0, 8'h00, 3'h0, 1'b0, 3'h7, 1'b1, 8'hfd},
    '{6'h00, 4'h1, 8'h00, 3'h0, 1'b0, 3'h7, 1'b1, 8'hf0},
    '{6'h00, 4'h2, 8'h00, 3'h0, 1'b0, 3'h7, 1'b1, 8'hf1},
    '{6'h00, 4'h4, 8'h00, 3'h0, 1'b0, 3'h7, 1'b1, 8'hf2},
    '{6'h00, 4'h8, 8'h00, 3'h0, 1'b0, 3'h7, 1'b1, 8'hf3},
    '{6'h00, 4'h0, 8'h04, 3'h5, 1'b1, 3'h4, 1'b1, 8'h02},
    '{6'h00, 4'h0, 8'h04, 3'h4, 1'b1, 3'h4, 1'b0, 8'h00},
    '{6'h00, 4'h0, 8'h08, 3'h7, 1'b0, 3'h0, 1'b0, 8'h00},
    '{6'h04, 4'h1, 8'h01, 3'h7, 1'b1, 3'h0, 1'b1, 8'hfa}
  };
  always #10 clk = ~clk;
  interrupt_and_context_restore #(.PERIPH_N(8)) i_interrupt_and_context_restore (
    .CLK(clk), .RESET_N(reset_n), .SPECIAL_REQ(special_req), .PERIPH_REQ(periph_req),
    .PERIPH_LEVEL(periph_level), .SOFT_EXEC(soft_exec), .ENABLE_FLAG(enable_flag),
    .PROCESSOR_PRIORITY_LEVEL(ppl), .FLAG_REGISTER(flags), .PC(pc), .SP_IN(sp_in),
    .INST_KIND(inst_kind), .INST_DONE(inst_done), .RESTORE_START(restore_start),
    .TASK_NUMBER_POINTER(task_ptr), .CONTEXT_TABLE_BASE(table_base), .MEM_RD(mem_rd),
    .MEM_WR(mem_wr), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
    .SUSPEND(suspend), .ENTRY_BUSY(entry_busy), .SERVICE_START(service_start),
    .VECTOR(vector), .SP_OUT(sp_out), .REG_LOAD(reg_load), .REG_INDEX(reg_index),
    .RESTORE_DONE(restore_done));
  stack_mem_model i_stack_mem_model (
    .clk(clk), .rd(mem_rd), .wr(mem_wr), .addr(mem_addr), .wdata(mem_wdata),
    .rdata(mem_rdata));
  // --------------------------------------------------
  // tasks
  // --------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_for(input logic svc, input int max, output int k);
    for (k = 1; k <= max; k++) begin
      @(negedge clk);
      if ((svc ? service_start : entry_busy) === 1'b1) return;
    end
    error_cnt++;
    $display("mismatch wait expected event seen timeout");
    end_sim();
  endtask
  task automatic quiet(input int cycles);
    int seen;
    seen = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (entry_busy !== 1'b0) seen++;
    end
    check("no_entry", seen, 0);
  endtask
  task automatic entry(input logic [7:0] vec);
    int k;
    logic [7:0] exp [5];
    exp = '{flags[15:8], flags[7:0], {4'h0, pc[19:16]}, pc[15:8], pc[7:0]};
    wait_for(1'b0, 20, k);
    check("suspend", suspend, inst_kind != INST_ORDINARY);
    @(posedge clk);
    special_req <= 6'h00;
    periph_req <= 8'h00;
    wait_for(1'b1, 10, k);
    check("entry_len", k, 5);
    check("vector", vector, vec);
    for (k = 1; k <= 5; k++) check("push", i_stack_mem_model.mem[sp_in - k], exp[k - 1]);
    check("entry_sp", sp_out, sp_in - 20'h00005);
  endtask
  task automatic release_req();
    for (int a = 1; a <= 5; a++) i_stack_mem_model.mem[sp_in - a] = 8'h00;
    @(posedge clk);
    special_req <= 6'h00;
    periph_req <= 8'h00;
    repeat (4) @(posedge clk);
  endtask
  // --------------------------------------------------
  // sequence
  // --------------------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    check("sp_rst", sp_out, 20'h00000);
    check("busy_rst", entry_busy, 1'b0);
    check("vec_rst", vector, 8'h00);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[r]) begin
      @(posedge clk);
      special_req <= rows[r].sp;
      periph_req <= rows[r].pr;
      periph_level <= {8{rows[r].lv}};
      enable_flag <= rows[r].en;
      ppl <= rows[r].pl;
      repeat (2) @(posedge clk);
      soft_exec <= rows[r].so;
      @(posedge clk);
      soft_exec <= 4'h0;
      if (rows[r].take) entry(rows[r].vec);
      else quiet(8);
      release_req();
    end
    // ordinary instruction still running, then a request inside entry
    inst_done <= 1'b0;
    periph_req <= 8'h01;
    periph_level <= {8{3'h6}};
    enable_flag <= 1'b1;
    ppl <= 3'h0;
    quiet(6);
    @(posedge clk);
    inst_done <= 1'b1;
    fork
      entry(8'h00);
      begin
        repeat (3) @(posedge clk);
        soft_exec <= 4'h2;
        @(posedge clk);
        soft_exec <= 4'h0;
      end
    join
    quiet(8);
    release_req();
    // string and sum-of-products instructions suspended mid-way
    foreach (kinds[q]) begin
      inst_kind <= kinds[q];
      inst_done <= 1'b0;
      periph_req <= 8'h01;
      entry(8'h00);
      @(posedge clk);
      inst_kind <= INST_ORDINARY;
      inst_done <= 1'b1;
      release_req();
    end
    // task context restore
    i_stack_mem_model.mem[12'h100] = 8'h03;
    i_stack_mem_model.mem[12'h206] = 8'ha5;
    i_stack_mem_model.mem[12'h207] = 8'h10;
    for (p = 0; p < 8; p++) i_stack_mem_model.mem[12'h800 + p] = 8'h40 + p;
    p = 0;
    @(posedge clk);
    restore_start <= 1'b1;
    @(posedge clk);
    restore_start <= 1'b0;
    for (n = 1; n <= 20; n++) begin
      @(negedge clk);
      if (n == 1) check("num_addr", mem_addr, 20'h00100);
      if (n == 2) check("mask_addr", mem_addr, 20'h00206);
      if (reg_load === 1'b1 && p < 4) begin
        check("reg_index", reg_index, exp_idx[p]);
        check("reg_data", mem_rdata, 8'h40 + p);
        check("sp_hold", sp_out, 20'h00800);
        p++;
      end
      if (restore_done === 1'b1) break;
    end
    check("done_cycle", n, 12);
    check("corr_addr", mem_addr, 20'h00207);
    check("pops", p, 4);
    @(negedge clk);
    check("sp_adj", sp_out, 20'h00810);
    // reset source aborts a restore mid-way
    @(posedge clk);
    restore_start <= 1'b1;
    @(posedge clk);
    restore_start <= 1'b0;
    special_req <= 6'h01;
    @(posedge clk);
    special_req <= 6'h00;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("abort_sp", sp_out, 20'h00000);
    quiet(6);
    end_sim();
  end
endmodule
